// *** core/acb_pkg.sv ***
`default_nettype none
package acb_pkg;

	// ****************************************
	// Instruction and type codes
	// ****************************************
	localparam logic [7:0] INSTR_ARITH     = 8'h13;
	localparam logic [7:0] INSTR_COMPARE   = 8'h14;
	localparam logic [7:0] INSTR_COND_JUMP = 8'h15;

	localparam logic [7:0] OP_ADD  = 8'h00;
	localparam logic [7:0] OP_SUB  = 8'h01;
	localparam logic [7:0] OP_MUL  = 8'h02;
	localparam logic [7:0] OP_DIV  = 8'h03;
	localparam logic [7:0] OP_MOD  = 8'h04;
	localparam logic [7:0] OP_AND  = 8'h05;
	localparam logic [7:0] OP_OR   = 8'h06;
	localparam logic [7:0] OP_XOR  = 8'h07;
	localparam logic [7:0] OP_NOT  = 8'h08;
	localparam logic [7:0] OP_LOAD = 8'h09;

	localparam logic [7:0] COND_RESULT_IS_NULL = 8'h00;
	localparam logic [7:0] COND_RESULT_NONNULL = 8'h01;
	localparam logic [7:0] COND_SAME_VALUES    = 8'h02;
	localparam logic [7:0] COND_VALUES_DIFFER  = 8'h03;
	localparam logic [7:0] COND_ABOVE          = 8'h04;
	localparam logic [7:0] COND_ABOVE_OR_SAME  = 8'h05;
	localparam logic [7:0] COND_BELOW          = 8'h06;
	localparam logic [7:0] COND_BELOW_OR_SAME  = 8'h07;
	localparam logic [7:0] COND_TIMEOUT_ERR    = 8'h08;
	localparam logic [7:0] COND_EXT_ALARM      = 8'h09;
	localparam logic [7:0] COND_DEVIATION_ERR  = 8'h0A;
	localparam logic [7:0] COND_POSITION_ERR   = 8'h0B;

	// ****************************************
	// Reply status codes
	// ****************************************
	localparam logic [7:0] STS_OK        = 8'h64;
	localparam logic [7:0] STS_BAD_INSTR = 8'h02;
	localparam logic [7:0] STS_BAD_TYPE  = 8'h03;

	// ****************************************
	// Register offsets (byte addresses)
	// ****************************************
	localparam logic [7:0] OFF_CTRL    = 8'h00;
	localparam logic [7:0] OFF_CMD     = 8'h04;
	localparam logic [7:0] OFF_OPERAND = 8'h08;
	localparam logic [7:0] OFF_OPBYTE  = 8'h0C;
	localparam logic [7:0] OFF_ACCU    = 8'h10;
	localparam logic [7:0] OFF_PC      = 8'h14;
	localparam logic [7:0] OFF_FLAGS   = 8'h18;
	localparam logic [7:0] OFF_ERRORS  = 8'h1C;
	localparam logic [7:0] OFF_RPL_STS = 8'h20;
	localparam logic [7:0] OFF_RPL_VAL = 8'h24;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int FLD_STANDALONE = 0;
	localparam int FLD_SAME       = 0;
	localparam int FLD_ABOVE      = 1;
	localparam int FLD_BELOW      = 2;
	localparam int FLD_TIMEOUT    = 0;
	localparam int FLD_ALARM      = 1;
	localparam int FLD_DEVIATION  = 2;
	localparam int FLD_POSITION   = 3;

	localparam logic [31:0] WORD_RST   = 32'h0000_0000;
	localparam logic [7:0]  RPL_STS_RST = 8'h00;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage
`default_nettype wire

// *** core/acb_core.sv ***
`default_nettype none
module acb_core
	import acb_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction
	// ****************************************
	// Bus slave
	// ****************************************
	logic        aw_full_q;
	logic        w_full_q;
	logic [7:0]  aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        rvalid_q;
	logic [1:0]  rresp_q;
	logic [31:0] rdata_q;
	logic [31:0] rd_word;
	logic        rd_hit;
	wire wr_fire = aw_full_q && w_full_q && !bvalid_q;
	wire wr_hit  = aw_addr_q <= OFF_RPL_VAL && aw_addr_q[1:0] == 2'h0;
	assign awready = !aw_full_q;
	assign wready  = !w_full_q;
	assign bvalid  = bvalid_q;
	assign bresp   = bresp_q;
	assign arready = !rvalid_q;
	assign rvalid  = rvalid_q;
	assign rresp   = rresp_q;
	assign rdata   = rdata_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			aw_addr_q <= 8'h00;
		end else if (awvalid && !aw_full_q) begin
			aw_full_q <= 1'b1;
			aw_addr_q <= awaddr;
		end else if (wr_fire) begin
			aw_full_q <= 1'b0;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_full_q <= 1'b0;
			w_data_q <= WORD_RST;
			w_strb_q <= 4'h0;
		end else if (wvalid && !w_full_q) begin
			w_full_q <= 1'b1;
			w_data_q <= wdata;
			w_strb_q <= wstrb;
		end else if (wr_fire) begin
			w_full_q <= 1'b0;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalid_q <= 1'b0;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rresp_q  <= RESP_OKAY;
			rdata_q  <= WORD_RST;
		end else if (arvalid && !rvalid_q) begin
			rvalid_q <= 1'b1;
			rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			rdata_q  <= rd_word;
		end else if (rready) begin
			rvalid_q <= 1'b0;
		end
	end
	sequence s_wr_taken;
		wr_fire;
	endsequence
	bus_write_resp_a: assert property (s_wr_taken |=> bvalid && wready && awready)
		else $error("write response missing after write taken");
	// ****************************************
	// Command registers
	// ****************************************
	logic        standalone_q;
	logic [31:0] cmd_q;
	logic [31:0] op_q;
	logic [31:0] acc_q;
	logic [31:0] pc_q;
	logic        same_q;
	logic        above_q;
	logic        below_q;
	logic [3:0]  err_q;
	logic [7:0]  rpl_sts_q;
	logic [31:0] rpl_val_q;
	wire wr_ctrl   = wr_fire && aw_addr_q == OFF_CTRL;
	wire exec      = wr_fire && aw_addr_q == OFF_CMD;
	wire wr_op     = wr_fire && aw_addr_q == OFF_OPERAND;
	wire wr_opbyte = wr_fire && aw_addr_q == OFF_OPBYTE;
	wire wr_acc    = wr_fire && aw_addr_q == OFF_ACCU;
	wire wr_pc     = wr_fire && aw_addr_q == OFF_PC;
	wire wr_err    = wr_fire && aw_addr_q == OFF_ERRORS;
	wire [31:0] cmd_w   = merge(cmd_q, w_data_q, w_strb_q);
	wire [7:0]  instr_w = cmd_w[7:0];
	wire [7:0]  type_w  = cmd_w[15:8];
	wire        is_arith = exec && instr_w == INSTR_ARITH;
	wire        is_comp  = exec && instr_w == INSTR_COMPARE;
	wire        is_jump  = exec && instr_w == INSTR_COND_JUMP;
	wire        arith_ok = type_w <= OP_LOAD;
	wire signed [31:0] acc_s = acc_q;
	wire signed [31:0] op_s  = op_q;
	wire        div_zero = op_q == WORD_RST;
	function automatic logic [7:0] rd_addr_sel(input logic [7:0] a);
		return (a[1:0] == 2'h0) ? a : 8'hFF;
	endfunction
	always_comb begin
		case (rd_addr_sel(araddr))
			OFF_CTRL:    rd_word = {31'h0, standalone_q};
			OFF_CMD:     rd_word = cmd_q;
			OFF_OPERAND: rd_word = op_q;
			OFF_OPBYTE:  rd_word = op_q;
			OFF_ACCU:    rd_word = acc_q;
			OFF_PC:      rd_word = pc_q;
			OFF_FLAGS:   rd_word = {29'h0, below_q, above_q, same_q};
			OFF_ERRORS:  rd_word = {28'h0, err_q};
			OFF_RPL_STS: rd_word = {24'h0, rpl_sts_q};
			OFF_RPL_VAL: rd_word = rpl_val_q;
			default:     rd_word = WORD_RST;
		endcase
	end
	assign rd_hit = rd_addr_sel(araddr) <= OFF_RPL_VAL;
	// ****************************************
	// Arithmetic unit
	// ****************************************
	logic [31:0] arith_instr_res;
	always_comb begin
		case (type_w)
			OP_ADD:  arith_instr_res = acc_q + op_q;
			OP_SUB:  arith_instr_res = acc_q - op_q;
			OP_MUL:  arith_instr_res = acc_q * op_q;
			// Division by zero keeps the accumulator instead of trapping
			OP_DIV:  arith_instr_res = div_zero ? acc_s : acc_s / op_s;
			OP_MOD:  arith_instr_res = div_zero ? acc_s : acc_s % op_s;
			OP_AND:  arith_instr_res = acc_q & op_q;
			OP_OR:   arith_instr_res = acc_q | op_q;
			OP_XOR:  arith_instr_res = acc_q ^ op_q;
			OP_NOT:  arith_instr_res = ~acc_q;
			OP_LOAD: arith_instr_res = op_q;
			default: arith_instr_res = acc_q;
		endcase
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_q <= WORD_RST;
		end else if (wr_acc) begin
			acc_q <= merge(acc_q, w_data_q, w_strb_q);
		end else if (is_arith && arith_ok) begin
			acc_q <= arith_instr_res;
		end
	end
	arith_instr_add_a: assert property (is_arith && type_w == OP_ADD
			|=> acc_q == $past(acc_q) + $past(op_q))
		else $error("add result wrong");
	arith_instr_xor_a: assert property (is_arith && type_w == OP_XOR
			|=> acc_q == ($past(acc_q) ^ $past(op_q)))
		else $error("xor result wrong");
	arith_instr_invert_a: assert property (is_arith && type_w == OP_NOT |=> acc_q == ~$past(acc_q))
		else $error("invert result wrong");
	arith_instr_load_a: assert property (is_arith && type_w == OP_LOAD |=> acc_q == $past(op_q))
		else $error("load result wrong");
	// ****************************************
	// Operand entry
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			op_q <= WORD_RST;
		end else if (wr_op) begin
			op_q <= merge(op_q, w_data_q, w_strb_q);
		end else if (wr_opbyte) begin
			// First byte written ends up as the top byte
			op_q <= {op_q[23:0], w_data_q[7:0]};
		end
	end
	operand_bytes_a: assert property (wr_opbyte
			|=> op_q == {$past(op_q[23:0]), $past(w_data_q[7:0])})
		else $error("operand byte order wrong");
	// ****************************************
	// Compare flags and jump conditions
	// ****************************************
	logic cond_true;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			same_q  <= 1'b0;
			above_q <= 1'b0;
			below_q <= 1'b0;
		end else if (is_comp) begin
			same_q  <= acc_q == op_q;
			above_q <= acc_s > op_s;
			below_q <= acc_s < op_s;
		end
	end
	always_comb begin
		case (type_w)
			COND_RESULT_IS_NULL: cond_true = same_q;
			COND_RESULT_NONNULL: cond_true = !same_q;
			COND_SAME_VALUES:    cond_true = same_q;
			COND_VALUES_DIFFER:  cond_true = !same_q;
			COND_ABOVE:          cond_true = above_q;
			COND_ABOVE_OR_SAME:  cond_true = above_q || same_q;
			COND_BELOW:          cond_true = below_q;
			COND_BELOW_OR_SAME:  cond_true = below_q || same_q;
			COND_TIMEOUT_ERR:    cond_true = err_q[FLD_TIMEOUT];
			COND_EXT_ALARM:      cond_true = err_q[FLD_ALARM];
			COND_DEVIATION_ERR:  cond_true = err_q[FLD_DEVIATION];
			COND_POSITION_ERR:   cond_true = err_q[FLD_POSITION];
			default:             cond_true = 1'b0;
		endcase
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			err_q <= 4'h0;
		end else if (wr_err) begin
			err_q <= w_data_q[3:0];
		end
	end
	compare_flags_a: assert property (is_comp |=> same_q == ($past(acc_q) == $past(op_q))
			&& below_q == ($signed($past(acc_q)) < $signed($past(op_q))) && $stable(acc_q))
		else $error("compare flags wrong");
	// ****************************************
	// Program counter
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pc_q <= WORD_RST;
		end else if (wr_pc) begin
			pc_q <= merge(pc_q, w_data_q, w_strb_q);
		end else if (is_jump && cond_true) begin
			pc_q <= op_q;
		end else if (exec && standalone_q) begin
			pc_q <= pc_q + 32'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			standalone_q <= 1'b0;
		end else if (wr_ctrl) begin
			standalone_q <= w_data_q[FLD_STANDALONE];
		end
	end

	jump_taken_a: assert property (is_jump && cond_true |=> pc_q == $past(op_q))
		else $error("taken jump did not load address");
	jump_ge_a: assert property (is_jump && type_w == COND_ABOVE_OR_SAME
			&& (above_q || same_q) |=> pc_q == $past(op_q))
		else $error("greater or equal jump missed");
	jump_skip_a: assert property (is_jump && !cond_true && standalone_q
			|=> pc_q == $past(pc_q) + 32'h1 && $stable(acc_q) && $stable(same_q))
		else $error("untaken jump did not advance");

	// ****************************************
	// Reply
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_q     <= WORD_RST;
			rpl_sts_q <= RPL_STS_RST;
			rpl_val_q <= WORD_RST;
		end else if (exec) begin
			cmd_q     <= cmd_w;
			rpl_val_q <= op_q;
			if (is_arith) begin
				rpl_sts_q <= arith_ok ? STS_OK : STS_BAD_TYPE;
			end else if (is_comp || is_jump) begin
				// Honoured in direct mode too; stored programs are the expected source
				rpl_sts_q <= STS_OK;
			end else begin
				rpl_sts_q <= STS_BAD_INSTR;
			end
		end
	end

	reply_ok_a: assert property (is_arith && arith_ok && !standalone_q
			|=> rpl_sts_q == STS_OK && rpl_val_q == $past(op_q))
		else $error("calculate reply wrong");

endmodule
`default_nettype wire

// *** test/acb_host.sv ***
`default_nettype none
module acb_host
	import acb_pkg::*;
(
	input  wire logic        aclk,
	output var logic [7:0]   awaddr,
	output var logic         awvalid,
	input  wire logic        awready,
	output var logic [31:0]  wdata,
	output var logic [3:0]   wstrb,
	output var logic         wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output var logic         bready,
	output var logic [7:0]   araddr,
	output var logic         arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output var logic         rready
);
	timeunit 1ns;
	timeprecision 1ns;

	// ****************************************
	// Bus master side of the host
	// ****************************************
	// Ready lines stay high so no strobe is ever lowered and raised in one step
	initial begin
		awaddr = 8'h00;
		awvalid = 1'b0;
		wdata = 32'h0000_0000;
		wstrb = 4'hF;
		wvalid = 1'b0;
		bready = 1'b1;
		araddr = 8'h00;
		arvalid = 1'b0;
		rready = 1'b1;
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
		logic done;
		done = 1'b0;
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (awvalid && awready) begin
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
				wdata <= ~d;
			end
			if (bvalid) begin
				resp = bresp;
				done = 1'b1;
			end
		end
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		logic done;
		done = 1'b0;
		araddr <= a;
		arvalid <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (arvalid && arready) begin
				arvalid <= 1'b0;
				araddr <= ~a;
			end
			if (rvalid) begin
				d = rdata;
				resp = rresp;
				done = 1'b1;
			end
		end
	endtask

	task automatic put_operand(input logic [31:0] v);
		logic [1:0] r;
		for (int i = 3; i >= 0; i--) begin
			wr(OFF_OPBYTE, {24'h00_0000, v[i*8 +: 8]}, r);
		end
	endtask

	// Branch commands only ever issued from standalone mode
	task automatic prog(input logic [7:0] instr, input logic [7:0] typ);
		logic [1:0] r;
		wr(OFF_CTRL, 32'h0000_0001, r);
		wr(OFF_CMD, {8'h00, 8'h03, typ, instr}, r);
	endtask
endmodule
`default_nettype wire

// *** test/test_accumulator_compare_branch.sv ***
`default_nettype none
module test_accumulator_compare_branch
	import acb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	typedef struct packed {
		logic [7:0]  op;
		logic [31:0] acc;
		logic [31:0] opd;
		logic [31:0] res;
	} acb_row_t;

	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	int          num_errors;
	int          checks_done;
	logic [11:0] taken_mask;
	logic [1:0]  r;
	logic [31:0] rd_val;

	acb_row_t rows [10] = '{
		'{OP_ADD,  32'h0000_0007, 32'h0000_0005, 32'h0000_000C},
		'{OP_SUB,  32'h0000_0003, 32'h0000_0005, 32'hFFFF_FFFE},
		'{OP_MUL,  32'h0000_0007, 32'hFFFF_EC78, 32'hFFFF_7748},
		'{OP_DIV,  32'hFFFF_FFF9, 32'h0000_0002, 32'hFFFF_FFFD},
		'{OP_MOD,  32'h0000_0007, 32'h0000_0003, 32'h0000_0001},
		'{OP_AND,  32'hF0F0_F0F0, 32'hFF00_FF00, 32'hF000_F000},
		'{OP_OR,   32'hF0F0_F0F0, 32'hFF00_FF00, 32'hFFF0_FFF0},
		'{OP_XOR,  32'hF0F0_F0F0, 32'hFF00_FF00, 32'h0FF0_0FF0},
		'{OP_NOT,  32'h1234_5678, 32'h0000_0055, 32'hEDCB_A987},
		'{OP_LOAD, 32'h1234_5678, 32'h0000_00A5, 32'h0000_00A5}
	};

	acb_core DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

	acb_host host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

	// ****************************************
	// Clock, checks and verdict
	// ****************************************
	initial aclk = 1'b0;
	always #50 aclk = ~aclk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic w(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] rs;
		host.wr(a, d, rs);
		chk({30'h0, rs}, {30'h0, RESP_OKAY});
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  rs;
		host.rd(a, d, rs);
		chk(d, e);
		chk({30'h0, rs}, {30'h0, RESP_OKAY});
	endtask

	task automatic close_out;
		$display("Checks %0d, errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Whole run is under five hundred cycles; this leaves ample margin
	initial begin
		repeat (20000) @(posedge aclk);
		num_errors++;
		$display("Error at %0t: run did not finish", $time);
		close_out;
	end

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		num_errors = 0;
		checks_done = 0;
		aresetn = 1'b0;
		// Conditions 0..11 after comparing -3 with 2, timeout and deviation raised
		taken_mask = 12'h5CA;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rc(OFF_ACCU, WORD_RST);
		rc(OFF_PC, WORD_RST);
		rc(OFF_FLAGS, WORD_RST);
		foreach (rows[i]) begin
			w(OFF_ACCU, rows[i].acc);
			w(OFF_OPERAND, rows[i].opd);
			w(OFF_CMD, {8'h00, 8'h07, rows[i].op, INSTR_ARITH});
			rc(OFF_ACCU, rows[i].res);
			rc(OFF_RPL_STS, {24'h00_0000, STS_OK});
			rc(OFF_RPL_VAL, rows[i].opd);
		end
		// Bad type, unknown code and division by zero all leave the accumulator
		w(OFF_CMD, {16'h0000, 8'h0A, INSTR_ARITH});
		rc(OFF_RPL_STS, {24'h00_0000, STS_BAD_TYPE});
		rc(OFF_ACCU, 32'h0000_00A5);
		w(OFF_CMD, {24'h00_0000, 8'h2A});
		rc(OFF_RPL_STS, {24'h00_0000, STS_BAD_INSTR});
		w(OFF_OPERAND, WORD_RST);
		w(OFF_CMD, {16'h0000, OP_DIV, INSTR_ARITH});
		rc(OFF_ACCU, 32'h0000_00A5);
		rc(OFF_RPL_STS, {24'h00_0000, STS_OK});
		host.put_operand(32'hFFFF_EC78);
		rc(OFF_OPERAND, 32'hFFFF_EC78);
		host.wr(8'h3C, 32'h1111_1111, r);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		host.rd(8'h3C, rd_val, r);
		chk(rd_val, WORD_RST);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		w(OFF_ACCU, 32'hFFFF_FFFD);
		w(OFF_OPERAND, 32'h0000_0002);
		host.prog(INSTR_COMPARE, 8'h00);
		rc(OFF_FLAGS, 32'h0000_0004);
		w(OFF_ERRORS, 32'h0000_0005);
		for (int c = 0; c < 12; c++) begin
			w(OFF_PC, 32'h0000_0005);
			w(OFF_OPERAND, 32'h0000_0040);
			host.prog(INSTR_COND_JUMP, c[7:0]);
			rc(OFF_PC, taken_mask[c] ? 32'h0000_0040 : 32'h0000_0006);
		end
		rc(OFF_ACCU, 32'hFFFF_FFFD);
		rc(OFF_FLAGS, 32'h0000_0004);
		w(OFF_OPERAND, 32'hFFFF_FFFC);
		host.prog(INSTR_COMPARE, 8'h00);
		rc(OFF_FLAGS, 32'h0000_0002);
		w(OFF_OPERAND, 32'h0000_0040);
		host.prog(INSTR_COND_JUMP, COND_ABOVE);
		rc(OFF_PC, 32'h0000_0040);
		w(OFF_OPERAND, 32'hFFFF_FFFD);
		host.prog(INSTR_COMPARE, 8'h00);
		rc(OFF_FLAGS, 32'h0000_0001);
		w(OFF_OPERAND, 32'h0000_0033);
		host.prog(INSTR_COND_JUMP, COND_RESULT_IS_NULL);
		rc(OFF_PC, 32'h0000_0033);
		w(OFF_OPERAND, 32'h0000_0044);
		host.prog(INSTR_COND_JUMP, COND_ABOVE_OR_SAME);
		rc(OFF_PC, 32'h0000_0044);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rc(OFF_ACCU, WORD_RST);
		rc(OFF_CTRL, WORD_RST);
		rc(OFF_PC, WORD_RST);
		rc(OFF_FLAGS, WORD_RST);
		rc(OFF_RPL_STS, {24'h00_0000, RPL_STS_RST});
		close_out;
	end
endmodule
`default_nettype wire
